// [logic/smo_ctrl.sv]
// Purpose: Stop-mode output states and retentive memory control.
// Assumes: run and program outputs come from logic on clk; pwr_fail is a pin.
// Notes:   Configuration is written to shadows and applied on commit.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module smo_ctrl (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [15:0] rdata_r,
  input  wire logic        run,
  input  wire logic [15:0] prog_dout,
  input  wire logic        prog_aw,
  input  wire logic [4:0]  prog_ach,
  input  wire logic [15:0] prog_adata,
  output var  logic [15:0] dout_r,
  output logic [511:0]     aout,
  input  wire logic        q_valid,
  input  wire logic [2:0]  q_area,
  input  wire logic [15:0] q_addr,
  input  wire logic        q_retentive_on_delay_timer,
  input  wire logic        q_status,
  output var  logic        r_valid_r,
  output var  logic        r_retain_r,
  input  wire logic        pwr_fail,
  output var  logic        save_req_r,
  output var  logic [3:0]  save_idx_r
);
  localparam int AO_N  = smo_pkg::AO_N;
  localparam int RNG_N = smo_pkg::RNG_N;

  // Shadow copy written by the bus, active copy used by the logic
  logic [15:0] ctrl_s_r;
  logic [15:0] dtab_s_r;
  logic [15:0] afrz_s_r [AO_N];
  logic [15:0] rcfg_s_r [RNG_N];
  logic [15:0] rbeg_s_r [RNG_N];
  logic [15:0] rend_s_r [RNG_N];
  logic        dfrz_a_r;
  logic        afrz_a_r;
  logic [15:0] dtab_a_r;
  logic [15:0] afrz_a_v_r [AO_N];
  logic [15:0] rcfg_a_r [RNG_N];
  logic [15:0] rbeg_a_r [RNG_N];
  logic [15:0] rend_a_r [RNG_N];
  logic        cfg_loaded_r;
  logic [15:0] aout_r [AO_N];
  logic        run_d_r;
  logic        pf_s;
  logic        pf_d_r;
  smo_pkg::smo_save_t save_st_r;

  // Decode
  wire         wr_ctrl   = wr && (addr == smo_pkg::OFS_CTRL);
  wire         wr_dtab   = wr && (addr == smo_pkg::OFS_DTAB);
  wire         wr_commit = wr && (addr == smo_pkg::OFS_COMMIT);
  wire         in_afrz   = (addr >= smo_pkg::OFS_AFRZ) && (addr <= smo_pkg::OFS_AFRZ_E);
  wire         in_rng    = (addr >= smo_pkg::OFS_RNG) && (addr <= smo_pkg::OFS_RNG_E);
  wire [7:0]   afrz_off  = addr - smo_pkg::OFS_AFRZ;
  wire [4:0]   afrz_idx  = afrz_off[4:0];
  wire [7:0]   rng_off   = addr - smo_pkg::OFS_RNG;
  wire [7:0]   rng_idx8  = rng_off / 8'(smo_pkg::RNG_STRIDE);
  wire [2:0]   rng_idx   = rng_idx8[2:0];
  wire [7:0]   rng_fld8  = rng_off % 8'(smo_pkg::RNG_STRIDE);
  wire [1:0]   rng_fld   = rng_fld8[1:0];
  wire         stop_edge = run_d_r && !run;
  wire         save_busy = (save_st_r == smo_pkg::SMO_SAVE);
  wire [15:0]  stat_w    = {13'h0000, save_busy, cfg_loaded_r, run};

  wire [15:0] rng_rd = (rng_fld == 2'h0) ? rcfg_s_r[rng_idx]
                     : (rng_fld == 2'h1) ? rbeg_s_r[rng_idx]
                     : rend_s_r[rng_idx];
  wire [15:0] rd_mux;
  assign rd_mux = (addr == smo_pkg::OFS_CTRL) ? ctrl_s_r
                : (addr == smo_pkg::OFS_DTAB) ? dtab_s_r
                : (addr == smo_pkg::OFS_STAT) ? stat_w
                : in_afrz ? afrz_s_r[afrz_idx]
                : in_rng  ? rng_rd
                : 16'h0000;

  // Register port: read data in the next cycle only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else if (ce) begin
      rdata_r <= rd ? rd_mux : 16'h0000;
    end
  end

  // Shadow configuration, written piecewise during download
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_s_r <= 16'h0000;
      dtab_s_r <= smo_pkg::DTAB_RST;
      for (int i = 0; i < AO_N; i++) afrz_s_r[i] <= smo_pkg::AFRZ_RST;
      for (int i = 0; i < RNG_N; i++) begin
        rcfg_s_r[i] <= smo_pkg::RNG_RST;
        rbeg_s_r[i] <= smo_pkg::RNG_RST;
        rend_s_r[i] <= smo_pkg::RNG_RST;
      end
    end else if (ce && wr) begin
      if (wr_ctrl) begin
        ctrl_s_r <= wdata;
      end else if (wr_dtab) begin
        dtab_s_r <= wdata;
      end else if (in_afrz) begin
        afrz_s_r[afrz_idx] <= wdata;
      end else if (in_rng && rng_fld == 2'h0) begin
        rcfg_s_r[rng_idx] <= wdata;
      end else if (in_rng && rng_fld == 2'h1) begin
        rbeg_s_r[rng_idx] <= wdata;
      end else if (in_rng) begin
        rend_s_r[rng_idx] <= wdata;
      end
    end
  end

  // Commit: the whole block takes effect at once, never half-written
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dfrz_a_r     <= 1'b0;
      afrz_a_r     <= 1'b0;
      dtab_a_r     <= smo_pkg::DTAB_RST;
      cfg_loaded_r <= 1'b0;
      for (int i = 0; i < AO_N; i++) afrz_a_v_r[i] <= smo_pkg::AFRZ_RST;
      for (int i = 0; i < RNG_N; i++) begin
        rcfg_a_r[i] <= smo_pkg::RNG_RST;
        rbeg_a_r[i] <= smo_pkg::RNG_RST;
        rend_a_r[i] <= smo_pkg::RNG_RST;
      end
    end else if (ce && wr_commit) begin
      dfrz_a_r     <= ctrl_s_r[smo_pkg::CTRL_DFRZ];
      afrz_a_r     <= ctrl_s_r[smo_pkg::CTRL_AFRZ];
      dtab_a_r     <= dtab_s_r;
      cfg_loaded_r <= 1'b1;
      for (int i = 0; i < AO_N; i++) afrz_a_v_r[i] <= afrz_s_r[i];
      for (int i = 0; i < RNG_N; i++) begin
        rcfg_a_r[i] <= rcfg_s_r[i];
        rbeg_a_r[i] <= rbeg_s_r[i];
        rend_a_r[i] <= rend_s_r[i];
      end
    end
  end

  // Digital outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_d_r <= 1'b0;
      dout_r  <= 16'h0000;
    end else if (ce) begin
      run_d_r <= run;
      if (run) begin
        dout_r <= prog_dout;
      end else if (stop_edge && !dfrz_a_r) begin
        dout_r <= dtab_a_r;
      end
    end
  end

  // Analog outputs; in stop nothing but the edge touches them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < AO_N; i++) aout_r[i] <= 16'h0000;
    end else if (ce) begin
      if (run && prog_aw) begin
        aout_r[prog_ach] <= prog_adata;
      end else if (stop_edge && !afrz_a_r) begin
        for (int i = 0; i < AO_N; i++) aout_r[i] <= afrz_a_v_r[i];
      end
    end
  end

  for (genvar g = 0; g < AO_N; g++) begin : g_aout
    assign aout[g*16 +: 16] = aout_r[g];
  end

  // Retention ranges
  logic [RNG_N-1:0] hit;
  logic [RNG_N-1:0] mcov;
  for (genvar g = 0; g < RNG_N; g++) begin : g_rng
    smo_range u_rng (
      .en       (rcfg_a_r[g][smo_pkg::RCFG_EN]),
      .area     (rcfg_a_r[g][smo_pkg::RCFG_AREA +: smo_pkg::AREA_W]),
      .start    (rbeg_a_r[g]),
      .stop     (rend_a_r[g]),
      .q_area   (q_area),
      .q_addr   (q_addr),
      .hit      (hit[g]),
      .mark_cov (mcov[g])
    );
  end

  // A timer only counts if retentive on-delay; timer and counter status bits never count
  wire kind_ok = (q_area != smo_pkg::AREA_T) || q_retentive_on_delay_timer;
  wire not_bit = !(q_status && (q_area == smo_pkg::AREA_T
                 || q_area == smo_pkg::AREA_C));
  wire retain  = (|hit) && kind_ok && not_bit;
  wire auto_en = |mcov;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_valid_r  <= 1'b0;
      r_retain_r <= 1'b0;
    end else if (ce) begin
      r_valid_r  <= q_valid;
      r_retain_r <= q_valid && retain;
    end
  end

  // Power-down auto save of marker bytes 0..13
  smo_sync u_pf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       (pwr_fail),
    .q       (pf_s)
  );

  wire pf_rise = pf_s && !pf_d_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_d_r     <= 1'b0;
      save_st_r  <= smo_pkg::SMO_IDLE;
      save_req_r <= 1'b0;
      save_idx_r <= 4'h0;
    end else if (ce) begin
      pf_d_r <= pf_s;
      case (save_st_r)
        smo_pkg::SMO_IDLE: begin
          save_req_r <= 1'b0;
          save_idx_r <= 4'h0;
          if (pf_rise && auto_en) begin
            save_st_r  <= smo_pkg::SMO_SAVE;
            save_req_r <= 1'b1;
          end
        end
        smo_pkg::SMO_SAVE: begin
          if (save_idx_r == smo_pkg::SAVE_LAST_IDX) begin
            save_st_r  <= smo_pkg::SMO_IDLE;
            save_req_r <= 1'b0;
            save_idx_r <= 4'h0;
          end else begin
            save_idx_r <= save_idx_r + 4'h1;
          end
        end
        default: save_st_r <= smo_pkg::SMO_IDLE;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_dtab;
    ce && stop_edge && !dfrz_a_r |=> dout_r == $past(dtab_a_r);
  endproperty
  a_dtab: assert property (p_dtab) else $error("stop table not applied");

  property p_dfrz;
    ce && stop_edge && dfrz_a_r |=> $stable(dout_r);
  endproperty
  a_dfrz: assert property (p_dfrz) else $error("frozen outputs moved");

  property p_afrz_val;
    ce && stop_edge && !afrz_a_r |=> aout[15:0] == $past(afrz_a_v_r[0]);
  endproperty
  a_afrz_val: assert property (p_afrz_val) else $error("analog freeze value");

  property p_ahold;
    ce && stop_edge && afrz_a_r |=> $stable(aout);
  endproperty
  a_ahold: assert property (p_ahold) else $error("analog not held");

  property p_stop_hold;
    !run && !run_d_r |=> $stable(dout_r) && $stable(aout);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("output moved in stop");

  property p_commit;
    !(ce && wr_commit) |=> $stable(dtab_a_r) && $stable(dfrz_a_r);
  endproperty
  a_commit: assert property (p_commit) else $error("config applied early");

  property p_tmr;
    ce && q_valid && q_area == smo_pkg::AREA_T && !q_retentive_on_delay_timer |=> !r_retain_r;
  endproperty
  a_tmr: assert property (p_tmr) else $error("plain timer retained");

  property p_bits;
    ce && q_valid && q_status && q_area == smo_pkg::AREA_C |=> !r_retain_r;
  endproperty
  a_bits: assert property (p_bits) else $error("counter bit retained");

  property p_area;
    ce && q_valid && q_area > smo_pkg::AREA_T |=> !r_retain_r;
  endproperty
  a_area: assert property (p_area) else $error("bad area retained");

  property p_save_len;
    ce && save_st_r == smo_pkg::SMO_IDLE && pf_rise && auto_en
      |=> save_req_r [*8] ##0 (save_idx_r == 4'h7);
  endproperty
  a_save_len: assert property (p_save_len) else $error("save sequence");

  property p_save_no;
    ce && save_st_r == smo_pkg::SMO_IDLE && !(pf_rise && auto_en) |=> !save_req_r;
  endproperty
  a_save_no: assert property (p_save_no) else $error("unwanted save");

  property p_no_hit;
    ce && q_valid && !(|hit) |=> !r_retain_r;
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("retained outside ranges");

  property p_run_copy;
    ce && run |=> dout_r == $past(prog_dout);
  endproperty
  a_run_copy: assert property (p_run_copy) else $error("program outputs not passed");

  c_ana_tab:  cover property (ce && stop_edge && !afrz_a_r);

  c_stop_tab: cover property (ce && stop_edge && !dfrz_a_r);
  c_stop_frz: cover property (ce && stop_edge && afrz_a_r);
  c_retain:   cover property (r_valid_r && r_retain_r);
  c_save:     cover property (save_req_r && save_idx_r == smo_pkg::SAVE_LAST_IDX);
endmodule : smo_ctrl
`default_nettype wire

// [logic/smo_pkg.sv]
// Purpose: Shared constants for the stop-mode output and retention block.
// Assumes: One 25 MHz clock; plain register port with 8-bit address.
// Notes:   Offsets, widths and reset values all live here.
package smo_pkg;
  localparam int DO_W     = 16;
  localparam int AO_N     = 32;
  localparam int AO_W     = 16;
  localparam int RNG_N    = 6;
  localparam int AREA_W   = 3;
  localparam int MADDR_W  = 16;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int SIDX_W   = 4;

  // Memory area codes
  localparam logic [2:0] AREA_V = 3'h0;
  localparam logic [2:0] AREA_M = 3'h1;
  localparam logic [2:0] AREA_C = 3'h2;
  localparam logic [2:0] AREA_T = 3'h3;

  // Marker bytes saved automatically at power down
  localparam logic [15:0] MARK_AUTO_FIRST = 16'h0000;
  localparam logic [15:0] MARK_AUTO_LAST  = 16'h000D;
  localparam logic [3:0]  SAVE_LAST_IDX   = 4'hD;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DTAB   = 8'h01;
  localparam logic [7:0] OFS_COMMIT = 8'h02;
  localparam logic [7:0] OFS_STAT   = 8'h03;
  localparam logic [7:0] OFS_AFRZ   = 8'h10;
  localparam logic [7:0] OFS_AFRZ_E = 8'h2F;
  localparam logic [7:0] OFS_RNG    = 8'h30;
  localparam logic [7:0] OFS_RNG_E  = 8'h41;
  localparam int         RNG_STRIDE = 3;

  // Field positions
  localparam int CTRL_DFRZ = 0;
  localparam int CTRL_AFRZ = 1;
  localparam int RCFG_EN   = 0;
  localparam int RCFG_AREA = 1;
  localparam int STAT_RUN  = 0;
  localparam int STAT_CFG  = 1;
  localparam int STAT_SAVE = 2;

  // Reset values
  localparam logic [15:0] DTAB_RST = 16'h0000;
  localparam logic [15:0] AFRZ_RST = 16'h0000;
  localparam logic [15:0] RNG_RST  = 16'h0000;

  typedef enum logic [1:0] {
    SMO_IDLE = 2'b01,
    SMO_SAVE = 2'b10
  } smo_save_t;
endpackage : smo_pkg

// [logic/smo_sync.sv]
// Purpose: Two-stage synchroniser for a pin input.
// Assumes: Input is asynchronous to clk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module smo_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic d,
  output var  logic q
);
  logic meta_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : smo_sync
`default_nettype wire

// [logic/smo_range.sv]
// Purpose: One retentive range: hit test and marker auto-save coverage.
// Assumes: Range is inclusive, start not above end.
// Notes:   Areas outside V, M, C and T never hit.
`timescale 1ns/1ns
`default_nettype none
module smo_range (
  input  wire logic        en,
  input  wire logic [2:0]  area,
  input  wire logic [15:0] start,
  input  wire logic [15:0] stop,
  input  wire logic [2:0]  q_area,
  input  wire logic [15:0] q_addr,
  output logic             hit,
  output logic             mark_cov
);
  wire area_ok = (area <= smo_pkg::AREA_T);
  assign hit = en && area_ok && (area == q_area)
               && (q_addr >= start) && (q_addr <= stop);
  assign mark_cov = en && (area == smo_pkg::AREA_M)
                    && (start == smo_pkg::MARK_AUTO_FIRST)
                    && (stop >= smo_pkg::MARK_AUTO_LAST);
endmodule : smo_range
`default_nettype wire

// [tb/smo_actuator.sv]
// Purpose: Field actuator model on the digital and analog outputs.
// Assumes: Outputs are sampled at mid-cycle, away from the launching edge.
// Notes:   Counts output changes seen once STOP has settled.
`timescale 1ns/1ns
`default_nettype none
module smo_actuator (
  input  wire logic         clk,
  input  wire logic         run,
  input  wire logic [15:0]  dout,
  input  wire logic [511:0] aout,
  output var  logic [7:0]   stop_chg
);
  logic [1:0]   run_h;
  logic [527:0] last;
  initial begin
    run_h    = 2'h3;
    stop_chg = 8'h00;
    last     = '0;
  end
  // Two low samples first, so the single STOP update itself is not counted
  always @(negedge clk) begin
    if (!run && run_h == 2'h0 && {dout, aout} != last) begin
      stop_chg <= stop_chg + 8'h01;
    end
    run_h <= {run_h[0], run};
    last  <= {dout, aout};
  end
endmodule : smo_actuator
`default_nettype wire

// [tb/smo_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the stop-mode output and retention block.
// Assumes: ce held high; bus and pins driven by non-blocking assignment.
// Notes:   Configuration is committed only where a test means it.
`timescale 1ns/1ns
`default_nettype none
module smo_ctrl_tb_top;
  logic         clk, sys_rst, wr, rd, run, prog_aw, q_valid, q_status;
  logic         q_retentive_on_delay_timer;
  logic         pwr_fail, r_valid_r, r_retain_r, save_req_r;
  logic [7:0]   addr, stop_chg;
  logic [15:0]  wdata, rdata_r, prog_dout, prog_adata, dout_r, q_addr, v;
  logic [4:0]   prog_ach;
  logic [2:0]   q_area;
  logic [3:0]   save_idx_r;
  logic [511:0] aout;
  logic [2:0]   ra [6];
  logic [15:0]  rs [6];
  logic [15:0]  re [6];
  int           n_errors, comparisons;

  smo_ctrl i_smo_ctrl (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .run(run),
    .prog_dout(prog_dout), .prog_aw(prog_aw), .prog_ach(prog_ach),
    .prog_adata(prog_adata), .dout_r(dout_r), .aout(aout), .q_valid(q_valid),
    .q_area(q_area), .q_addr(q_addr), .q_status(q_status),
    .q_retentive_on_delay_timer(q_retentive_on_delay_timer),
    .r_valid_r(r_valid_r), .r_retain_r(r_retain_r), .pwr_fail(pwr_fail),
    .save_req_r(save_req_r), .save_idx_r(save_idx_r));
  smo_actuator i_smo_actuator (.clk(clk), .run(run), .dout(dout_r), .aout(aout),
    .stop_chg(stop_chg));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bw(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bw
  task automatic br(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_r;
  endtask : br
  task automatic aw(input logic [4:0] ch, input logic [15:0] d);
    @(posedge clk);
    prog_aw    <= 1'b1;
    prog_ach   <= ch;
    prog_adata <= d;
    @(posedge clk);
    prog_aw <= 1'b0;
  endtask : aw
  task automatic go_run(input logic [15:0] d);
    @(posedge clk);
    run       <= 1'b1;
    prog_dout <= d;
  endtask : go_run
  task automatic to_stop;
    @(posedge clk);
    run <= 1'b0;
    step(2);
  endtask : to_stop
  task automatic qry(input logic [2:0] ar, input logic [15:0] ad, input logic t,
                     input logic s, input logic e);
    @(posedge clk);
    q_valid  <= 1'b1;
    q_area   <= ar;
    q_addr   <= ad;
    q_retentive_on_delay_timer <= t;
    q_status <= s;
    @(posedge clk);
    q_valid <= 1'b0;
    #1 chk({14'h0, r_valid_r, r_retain_r}, {14'h0, 1'b1, e});
  endtask : qry
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Whole run is about 150 cycles; the 10000-cycle limit is ample margin
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial begin
    {sys_rst, wr, rd, run, prog_aw, q_valid, q_retentive_on_delay_timer, q_status,
     pwr_fail} = 9'h100;
    {addr, wdata, prog_dout, prog_ach, prog_adata, q_area, q_addr} = '0;
    ra = '{smo_pkg::AREA_M, smo_pkg::AREA_T, smo_pkg::AREA_C, 3'h4, smo_pkg::AREA_V,
           smo_pkg::AREA_M};
    rs = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0014};
    re = '{16'h000D, 16'h0009, 16'h0009, 16'h00FF, 16'h00C8, 16'h001E};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    br(smo_pkg::OFS_DTAB, v);
    chk(v, smo_pkg::DTAB_RST);
    br(smo_pkg::OFS_AFRZ_E, v);
    chk(v, smo_pkg::AFRZ_RST);
    br(smo_pkg::OFS_RNG, v);
    chk(v, smo_pkg::RNG_RST);
    br(smo_pkg::OFS_STAT, v);
    chk(v, 16'h0000);
    br(8'hFF, v);
    chk(v, 16'h0000);
    qry(smo_pkg::AREA_M, 16'h0005, 1'b0, 1'b0, 1'b0);
    $display("test defaults done");
    bw(smo_pkg::OFS_DTAB, 16'h00A5);
    bw(smo_pkg::OFS_AFRZ, 16'h8000);
    bw(smo_pkg::OFS_AFRZ_E, 16'h7FFF);
    go_run(16'hFFFF);
    aw(5'h00, 16'h1234);
    step(2);
    chk(dout_r, 16'hFFFF);
    chk(aout[15:0], 16'h1234);
    to_stop();
    chk(dout_r, 16'h0000);
    chk(aout[15:0], 16'h0000);
    $display("test uncommitted done");
    bw(smo_pkg::OFS_COMMIT, 16'h0000);
    br(smo_pkg::OFS_STAT, v);
    chk(v & 16'h0002, 16'h0002);
    go_run(16'hFFFF);
    aw(5'h00, 16'h1234);
    aw(5'h1F, 16'h4321);
    step(2);
    to_stop();
    chk(dout_r, 16'h00A5);
    chk(aout[15:0], 16'h8000);
    chk(aout[511:496], 16'h7FFF);
    @(posedge clk);
    prog_dout <= 16'h0F0F;
    aw(5'h00, 16'h0001);
    step(4);
    chk(dout_r, 16'h00A5);
    chk(aout[15:0], 16'h8000);
    $display("test table done");
    bw(smo_pkg::OFS_CTRL, 16'h0003);
    bw(smo_pkg::OFS_COMMIT, 16'h0000);
    go_run(16'h5A5A);
    br(smo_pkg::OFS_STAT, v);
    chk(v, 16'h0003);
    aw(5'h03, 16'h4321);
    step(2);
    to_stop();
    chk(dout_r, 16'h5A5A);
    chk(aout[63:48], 16'h4321);
    chk(aout[15:0], 16'h8000);
    chk({8'h00, stop_chg}, 16'h0000);
    $display("test freeze done");
    for (int k = 0; k < smo_pkg::RNG_N; k++) begin
      bw(smo_pkg::OFS_RNG + 8'(smo_pkg::RNG_STRIDE * k), {12'h000, ra[k], 1'b1});
      bw(smo_pkg::OFS_RNG + 8'(smo_pkg::RNG_STRIDE * k + 1), rs[k]);
      bw(smo_pkg::OFS_RNG + 8'(smo_pkg::RNG_STRIDE * k + 2), re[k]);
    end
    br(smo_pkg::OFS_RNG_E, v);
    chk(v, 16'h001E);
    qry(smo_pkg::AREA_M, 16'h0000, 1'b0, 1'b0, 1'b0);
    bw(smo_pkg::OFS_COMMIT, 16'h0000);
    qry(smo_pkg::AREA_M, 16'h0000, 1'b0, 1'b0, 1'b1);
    qry(smo_pkg::AREA_M, 16'h000D, 1'b0, 1'b0, 1'b1);
    qry(smo_pkg::AREA_M, 16'h000E, 1'b0, 1'b0, 1'b0);
    qry(smo_pkg::AREA_M, 16'h0019, 1'b0, 1'b0, 1'b1);
    qry(smo_pkg::AREA_V, 16'h0096, 1'b0, 1'b0, 1'b1);
    qry(3'h4, 16'h000A, 1'b0, 1'b0, 1'b0);
    qry(smo_pkg::AREA_T, 16'h0005, 1'b1, 1'b0, 1'b1);
    qry(smo_pkg::AREA_T, 16'h0005, 1'b0, 1'b0, 1'b0);
    qry(smo_pkg::AREA_T, 16'h0005, 1'b1, 1'b1, 1'b0);
    qry(smo_pkg::AREA_C, 16'h0005, 1'b0, 1'b0, 1'b1);
    qry(smo_pkg::AREA_C, 16'h0005, 1'b0, 1'b1, 1'b0);
    $display("test retention done");
    @(posedge clk);
    pwr_fail <= 1'b1;
    for (int i = 0; i < 10 && save_req_r !== 1'b1; i++) step(1);
    for (int i = 0; i < 14; i++) begin
      chk({11'h000, save_req_r, save_idx_r}, {11'h000, 1'b1, 4'(i)});
      step(1);
    end
    chk({15'h0000, save_req_r}, 16'h0000);
    $display("test power down done");
    wrap_up();
  end
endmodule : smo_ctrl_tb_top
`default_nettype wire
